// [sar_adc_sequence_timing.v]
// Sequencing and timing controller of a successive-approximation converter
// Overview of operation
// [R01] Discharge phase performed or skipped by discharge_select
// [R02] Discharge lasts exactly two operating clocks
// [R03] Writing 1 clears limit flag within one clock
// [R04] Selector gives 14..21, then 29..141 conversion clocks
// [R05] Discharge adds two clocks beyond conversion count
// [R06] Selector gives 1..8, then 16..128 sample clocks
// [R07] Software avoids prohibited settings with external reference
// [R08] Software uses only allowed settings with internal reference
// [R09] Self-test selects full, zero or reference input
// [R10] Software enables internal reference before self-test
// [R11] Self-test applies to channels 0 through 15
// [R12] Test conversions leave normal conversions undisturbed
// [R13] Test inputs give distinct results from normal
// [R14] Continuous mode repeats scan without software restart
// [R15] Hardware trigger may start one-time scan
// [R16] Conversion continues while processor halts
// [R17] Limit condition codes: in, above, above lower, outside
// [R18] Limit flags frozen while limit detection disabled
// [R19] Interrupt after scan, or after each channel; with limit detection enabled the code interrupts only on a limit hit
// [R20] Channel order: discharge, sample, approximate, store
//
// Our own choices: the address map and register access over APB.
`include "adc_seq_map.vh"
module sar_adc_sequence_timing #(
    parameter NCH = 16,
    parameter RES = 10
) (
    input wire ref_clk_i,
    input wire sys_rst_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    input wire trigger_i,
    input wire halt_i,
    input wire comp_i,
    output reg [RES-1:0] dac_code_o,
    output reg discharge_o,
    output reg sample_o,
    output reg [3:0] analog_input_n_o,
    output reg [1:0] self_test_select_o,
    output reg [7:0] reference_control_o,
    output reg converter_op_clock_o,
    output reg irq_o
);
    localparam ST_IDLE = 3'd0;
    localparam ST_DISCH = 3'd1;
    localparam ST_SAMPLE = 3'd2;
    localparam ST_CONV = 3'd3;
    localparam ST_STORE = 3'd4;

    reg [15:0] mode_q;
    reg [NCH-1:0] chsel_q;
    reg [15:0] limmod_q;
    reg [RES-1:0] upper_q;
    reg [RES-1:0] lower_q;
    reg irqmod_q;
    reg [NCH-1:0] limit_hit_status_q;
    reg [RES-1:0] result_q [0:NCH-1];
    reg [2:0] state_q;
    reg [7:0] cnt_q;
    reg [3:0] ch_q;
    reg [RES-1:0] sar_q;
    reg [3:0] bit_q;
    reg [7:0] div_q;
    reg trig_s1_q, trig_s2_q, trig_s3_q;
    reg comp_s1_q, comp_s2_q;
    reg halt_s1_q, halt_s2_q;
    reg busy_q;

    wire tick = (div_q == 8'h00);
    wire [3:0] tsel = mode_q[`MODE_TSEL_HI:`MODE_TSEL_LO];
    wire [2:0] cksel = mode_q[`MODE_CKSEL_HI:`MODE_CKSEL_LO];
    wire [1:0] lim_cond = limmod_q[`LIM_COND_HI:`LIM_COND_LO];
    wire wr = psel_i & penable_i & pwrite_i;
    wire trig_edge = trig_s2_q & ~trig_s3_q;
    reg [7:0] conv_cnt;
    reg [7:0] samp_cnt;
    reg hit;
    reg [3:0] next_ch;
    reg more;
    integer i;

    // Counts from the four-bit selector
    always @*
    begin
        if (!tsel[3])
        begin
            conv_cnt = {5'h00, tsel[2:0]} + 8'h0e; // see [R04]
            samp_cnt = {5'h00, tsel[2:0]} + 8'h01; // see [R06]
        end
        else
        begin
            conv_cnt = {1'b0, tsel[2:0], 4'h0} + 8'h1d; // see [R04]
            samp_cnt = {1'b0, tsel[2:0], 4'h0} + 8'h10; // see [R06]
        end
    end

    // Limit compare on the value being stored
    always @*
    begin
        case (lim_cond) // see [R17]
            `LIM_IN: hit = (sar_q >= lower_q) && (sar_q <= upper_q);
            `LIM_ABOVE_UP: hit = sar_q > upper_q;
            `LIM_ABOVE_LO: hit = sar_q > lower_q;
            default: hit = (sar_q > upper_q) || (sar_q < lower_q);
        endcase
    end

    reg [3:0] first_ch;
    // Next and lowest selected channel in one loop, so the index has one driver
    always @*
    begin
        next_ch = ch_q;
        more = 1'b0;
        first_ch = 4'h0;
        for (i = NCH - 1; i >= 0; i = i - 1)
        begin
            if (chsel_q[i] && (i > ch_q))
            begin
                next_ch = i[3:0];
                more = 1'b1;
            end
            if (chsel_q[i])
            begin
                first_ch = i[3:0];
            end
        end
    end

    // Operating clock enable; halt does not stop it, so scans finish in halt
    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            div_q <= 8'h00;
            converter_op_clock_o <= 1'b0;
        end
        else
        begin
            if (tick)
            begin
                div_q <= (8'h01 << cksel) - 8'h01; // see [R16]
            end
            else
            begin
                div_q <= div_q - 8'h01;
            end
            converter_op_clock_o <= tick;
        end
    end

    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            trig_s1_q <= 1'b0;
            trig_s2_q <= 1'b0;
            trig_s3_q <= 1'b0;
            comp_s1_q <= 1'b0;
            comp_s2_q <= 1'b0;
            halt_s1_q <= 1'b0;
            halt_s2_q <= 1'b0;
        end
        else
        begin
            trig_s1_q <= trigger_i;
            trig_s2_q <= trig_s1_q;
            trig_s3_q <= trig_s2_q;
            comp_s1_q <= comp_i;
            comp_s2_q <= comp_s1_q;
            halt_s1_q <= halt_i;
            halt_s2_q <= halt_s1_q;
        end
    end

    // Register file and sequencer share one process so run bits have one driver
    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            mode_q <= 16'h0000;
            chsel_q <= {NCH{1'b0}};
            limmod_q <= 16'h0000;
            upper_q <= `UPPER_RST;
            lower_q <= `LOWER_RST;
            irqmod_q <= 1'b0;
            reference_control_o <= 8'h00;
            self_test_select_o <= 2'h0;
            limit_hit_status_q <= {NCH{1'b0}};
            state_q <= ST_IDLE;
            cnt_q <= 8'h00;
            ch_q <= 4'h0;
            sar_q <= {RES{1'b0}};
            bit_q <= 4'h0;
            busy_q <= 1'b0;
            dac_code_o <= {RES{1'b0}};
            discharge_o <= 1'b0;
            sample_o <= 1'b0;
            analog_input_n_o <= 4'h0;
            irq_o <= 1'b0;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h00000000;
        end
        else
        begin
            irq_o <= 1'b0;
            pready_o <= psel_i & ~penable_i;
            pslverr_o <= 1'b0;
            if (psel_i & ~penable_i)
            begin
                case (paddr_i)
                    `OFS_MODE: prdata_o <= {16'h0000, mode_q[15:1], busy_q};
                    `OFS_CHSEL: prdata_o <= {{(32-NCH){1'b0}}, chsel_q};
                    `OFS_LIMMOD: prdata_o <= {16'h0000, limmod_q};
                    `OFS_UPPER: prdata_o <= {{(32-RES){1'b0}}, upper_q};
                    `OFS_LOWER: prdata_o <= {{(32-RES){1'b0}}, lower_q};
                    `OFS_REFCON: prdata_o <= {24'h000000, reference_control_o};
                    `OFS_IRQMOD: prdata_o <= {31'h00000000, irqmod_q};
                    `OFS_TEST: prdata_o <= {30'h00000000, self_test_select_o};
                    `OFS_STATUS: prdata_o <= {24'h000000, halt_s2_q, state_q, ch_q};
                    `OFS_LIMSTAT: prdata_o <= {{(32-NCH){1'b0}}, limit_hit_status_q};
                    default:
                    begin
                        if (paddr_i[11:8] == 4'h1)
                        begin
                            prdata_o <= {{(32-RES){1'b0}}, result_q[paddr_i[5:2]]};
                        end
                        else
                        begin
                            prdata_o <= 32'h00000000;
                            pslverr_o <= (paddr_i != `OFS_RESULT);
                        end
                    end
                endcase
            end
            if (wr & pready_o)
            begin
                case (paddr_i)
                    `OFS_MODE: mode_q <= pwdata_i[15:0];
                    `OFS_CHSEL: chsel_q <= pwdata_i[NCH-1:0];
                    `OFS_LIMMOD: limmod_q <= pwdata_i[15:0];
                    `OFS_UPPER: upper_q <= pwdata_i[RES-1:0];
                    `OFS_LOWER: lower_q <= pwdata_i[RES-1:0];
                    `OFS_REFCON: reference_control_o <= pwdata_i[7:0]; // see [R10]
                    `OFS_IRQMOD: irqmod_q <= pwdata_i[0];
                    `OFS_TEST: self_test_select_o <= pwdata_i[1:0]; // see [R09]
                    `OFS_LIMSTAT:
                        limit_hit_status_q <= limit_hit_status_q & ~pwdata_i[NCH-1:0]; // see [R03]
                    default: ;
                endcase
            end
            // Start from software run bit or the synchronised trigger edge
            if (state_q == ST_IDLE && !busy_q && chsel_q != {NCH{1'b0}})
            begin
                if (mode_q[`MODE_RUN] || (mode_q[`MODE_TRIG_EN] && trig_edge)) // see [R15]
                begin
                    busy_q <= 1'b1;
                    ch_q <= first_ch;
                    analog_input_n_o <= first_ch; // see [R11]
                end
            end
            if (busy_q && tick)
            begin
                case (state_q)
                    ST_IDLE:
                    begin
                        sar_q <= {RES{1'b0}};
                        if (mode_q[`MODE_DISCH]) // see [R01]
                        begin
                            state_q <= ST_DISCH;
                            discharge_o <= 1'b1;
                            cnt_q <= `DISCH_CYCLES - 8'h01; // see [R02] [R05]
                        end
                        else
                        begin
                            state_q <= ST_SAMPLE;
                            sample_o <= 1'b1;
                            cnt_q <= samp_cnt - 8'h01;
                        end
                    end
                    ST_DISCH:
                    begin
                        if (cnt_q == 8'h00)
                        begin
                            discharge_o <= 1'b0;
                            sample_o <= 1'b1; // see [R20]
                            state_q <= ST_SAMPLE;
                            cnt_q <= samp_cnt - 8'h01;
                        end
                        else
                        begin
                            cnt_q <= cnt_q - 8'h01;
                        end
                    end
                    ST_SAMPLE:
                    begin
                        if (cnt_q == 8'h00)
                        begin
                            sample_o <= 1'b0;
                            state_q <= ST_CONV;
                            cnt_q <= conv_cnt - 8'h01; // see [R04]
                            bit_q <= RES[3:0] - 4'h1;
                            dac_code_o <= {1'b1, {(RES-1){1'b0}}};
                        end
                        else
                        begin
                            cnt_q <= cnt_q - 8'h01;
                        end
                    end
                    ST_CONV:
                    begin
                        // Comparator passes two flops: op clocks above a quarter rate decide stale bits
                        if (cnt_q >= conv_cnt - RES[7:0] && bit_q != 4'hf)
                        begin
                            sar_q[bit_q] <= comp_s2_q;
                            if (bit_q != 4'h0)
                            begin
                                dac_code_o <= (sar_q | ({{(RES-1){1'b0}}, comp_s2_q} << bit_q))
                                    | ({{(RES-1){1'b0}}, 1'b1} << (bit_q - 4'h1));
                            end
                            bit_q <= bit_q - 4'h1;
                        end
                        if (cnt_q == 8'h00)
                        begin
                            state_q <= ST_STORE;
                        end
                        else
                        begin
                            cnt_q <= cnt_q - 8'h01;
                        end
                    end
                    default:
                    begin
                        result_q[ch_q] <= sar_q; // see [R20] [R12] [R13]
                        if (limmod_q[`LIM_EN] && hit) // see [R18]
                        begin
                            limit_hit_status_q[ch_q] <= 1'b1;
                        end
                        state_q <= ST_IDLE;
                        irq_o <= limmod_q[`LIM_EN] ? hit : (irqmod_q | ~more); // see [R19]
                        if (more)
                        begin
                            ch_q <= next_ch;
                            analog_input_n_o <= next_ch;
                        end
                        else if (mode_q[`MODE_CONT]) // see [R14]
                        begin
                            ch_q <= first_ch;
                            analog_input_n_o <= first_ch;
                        end
                        else
                        begin
                            busy_q <= 1'b0;
                            mode_q[`MODE_RUN] <= 1'b0;
                        end
                    end
                endcase
            end
        end
    end
endmodule // sar_adc_sequence_timing

// [adc_seq_map.vh]
// Register offsets, field positions, reset values and timing counts of the converter sequencer
`ifndef ADC_SEQ_MAP_VH
`define ADC_SEQ_MAP_VH
`define OFS_MODE 12'h000
`define OFS_CHSEL 12'h004
`define OFS_LIMMOD 12'h008
`define OFS_UPPER 12'h00c
`define OFS_LOWER 12'h010
`define OFS_REFCON 12'h014
`define OFS_IRQMOD 12'h018
`define OFS_TEST 12'h01c
`define OFS_STATUS 12'h020
`define OFS_LIMSTAT 12'h024
`define OFS_RESULT 12'h028
`define MODE_RUN 0
`define MODE_CONT 1
`define MODE_TRIG_EN 2
`define MODE_DISCH 3
`define MODE_TSEL_LO 4
`define MODE_TSEL_HI 7
`define MODE_CKSEL_LO 8
`define MODE_CKSEL_HI 10
`define LIM_EN 0
`define LIM_COND_LO 8
`define LIM_COND_HI 9
`define UPPER_RST 10'h3ff
`define LOWER_RST 10'h000
`define DISCH_CYCLES 8'h02
`define TEST_FULL 2'h1
`define TEST_ZERO 2'h2
`define TEST_VREF 2'h3
`define LIM_IN 2'h0
`define LIM_ABOVE_UP 2'h1
`define LIM_ABOVE_LO 2'h2
`define LIM_OUTSIDE 2'h3
`define DIV_DEFAULT 8
`endif

// [sar_adc_seq_chk_props.sv]
// Port-level assertions for the converter sequencer
`include "adc_seq_map.vh"
module sar_adc_seq_chk #(
    parameter NCH = 16,
    parameter RES = 10
) (
    input wire ref_clk_i,
    input wire sys_rst_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire pready_o,
    input wire pslverr_o,
    input wire discharge_o,
    input wire sample_o,
    input wire [7:0] reference_control_o,
    input wire converter_op_clock_o,
    input wire irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    wire wr = psel_i && penable_i && pready_o && pwrite_i;
    wire [8:0] tick = {8'h0, converter_op_clock_o};
    reg [4:0] mode_q;
    reg [7:0] ref_q;
    reg s_q;
    reg d_q;
    reg [8:0] scnt_q;
    reg [8:0] dcnt_q;
    reg [8:0] ccnt_q;
    function automatic [8:0] samp_len(input [3:0] t);
        samp_len = t[3] ? ({6'h0, t[2:0]} + 9'h1) << 4 : {6'h0, t[2:0]} + 9'h1;
    endfunction
    function automatic [8:0] conv_len(input [3:0] t);
        conv_len = t[3] ? 9'h1d + ({6'h0, t[2:0]} << 4) : 9'he + {6'h0, t[2:0]};
    endfunction
    // Phase lengths are counted in operating clock ticks, so any divider works
    always @(posedge ref_clk_i)
    begin
        s_q <= sample_o;
        d_q <= discharge_o;
        scnt_q <= sample_o ? (s_q ? scnt_q + tick : tick) : scnt_q;
        dcnt_q <= discharge_o ? (d_q ? dcnt_q + tick : tick) : dcnt_q;
        ccnt_q <= sample_o ? 9'h0 : ccnt_q + (tick & {9{~&ccnt_q}});
        if (wr && paddr_i == `OFS_REFCON)
            ref_q <= pwdata_i[7:0];
        if (sys_rst_i)
            mode_q <= 5'h0;
        else if (wr && paddr_i == `OFS_MODE)
            mode_q <= pwdata_i[`MODE_TSEL_HI:`MODE_DISCH];
    end
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (sys_rst_i);
    sequence s_setup;
        psel_i && !penable_i;
    endsequence
    sequence s_ref_write;
        wr && paddr_i == `OFS_REFCON;
    endsequence
    a_ready_after_setup: assert property (s_setup |=> pready_o)
        else $error("no ready in access cycle");
    a_ready_one_cycle: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    a_error_with_ready: assert property (pslverr_o |-> pready_o)
        else $error("error response without ready");
    a_ref_follows: assert property (s_ref_write |=> ##1 reference_control_o == ref_q)
        else $error("reference control output not updated");
    a_disch_gated: assert property ($rose(discharge_o) |-> mode_q[0])
        else $error("discharge while deselected");
    a_disch_length: assert property ($fell(discharge_o) |-> dcnt_q == 9'h2)
        else $error("discharge length wrong");
    a_disch_then_sample: assert property ($fell(discharge_o) |-> ##[0:1] sample_o)
        else $error("sample does not follow discharge");
    a_sample_length: assert property ($fell(sample_o) |-> scnt_q == samp_len(mode_q[4:1]))
        else $error("sample length wrong");
    a_conv_length: assert property (irq_o |-> ccnt_q >= conv_len(mode_q[4:1])
        && ccnt_q <= conv_len(mode_q[4:1]) + 9'h2)
        else $error("conversion length wrong");
endmodule // sar_adc_seq_chk

bind sar_adc_sequence_timing sar_adc_seq_chk #(.NCH(NCH), .RES(RES)) i_chk (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .discharge_o(discharge_o), .sample_o(sample_o),
    .reference_control_o(reference_control_o), .converter_op_clock_o(converter_op_clock_o),
    .irq_o(irq_o));

// [sar_analog_model.sv]
// Behavioural sample/hold and single comparator on the converter's analog side
module sar_analog_model #(
    parameter RES = 10
) (
    input wire ref_clk_i,
    input wire sample_i,
    input wire [3:0] channel_i,
    input wire [1:0] test_sel_i,
    input wire [RES-1:0] dac_code_i,
    output wire comp_o
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [RES-1:0] held_q = '0;
    // Channel levels avoid the test levels so every result is distinguishable
    function automatic [RES-1:0] level(input [3:0] ch, input [1:0] t);
        case (t)
            2'h1: level = {RES{1'b1}};
            2'h2: level = {RES{1'b0}};
            2'h3: level = RES'(10'h27a);
            default: level = RES'(10'h0a5 + 10'h31 * {6'h0, ch});
        endcase
    endfunction
    // Level is frozen outside sampling, as a hold capacitor would keep it
    always @(posedge ref_clk_i)
        if (sample_i)
            held_q <= level(channel_i, test_sel_i);
    assign comp_o = held_q >= dac_code_i;
endmodule // sar_analog_model

// [tb_sar_adc_sequence_timing.sv]
// Self-checking testbench of the converter sequencer
`include "adc_seq_map.vh"
module tb_sar_adc_sequence_timing;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic trig = 1'b0;
    logic halt = 1'b0;
    logic [11:0] addr = 12'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] prdata, rdata;
    logic pready, pslverr, comp, disch, samp, tick, irq, err;
    logic [9:0] dac, norm;
    logic [9:0] tres [4];
    logic [3:0] ain;
    logic [1:0] tst;
    logic [7:0] refc;
    int miscompares = 0;
    int checked = 0;
    int irqs = 0;
    int base, i;

    sar_adc_sequence_timing i_dut (.ref_clk_i(clk), .sys_rst_i(rst), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(addr), .pwdata_i(wdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .trigger_i(trig), .halt_i(halt), .comp_i(comp),
        .dac_code_o(dac), .discharge_o(disch), .sample_o(samp), .analog_input_n_o(ain),
        .self_test_select_o(tst), .reference_control_o(refc), .converter_op_clock_o(tick),
        .irq_o(irq));
    sar_analog_model i_ana (.ref_clk_i(clk), .sample_i(samp), .channel_i(ain),
        .test_sel_i(tst), .dac_code_i(dac), .comp_o(comp));

    initial
    begin
        forever #4 clk = ~clk;
    end
    always @(posedge clk) irqs <= irqs + irq;

    task check(input logic [31:0] seen, input logic [31:0] exp);
    begin
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    end
    endtask

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
    begin
        @(posedge clk);
        psel <= 1'b1;
        pwr <= wr;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20) miscompares++;
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    end
    endtask

    task rd(input logic [11:0] a, input logic [31:0] exp);
    begin
        apb(1'b0, a, 32'h0);
        check(rdata, exp);
    end
    endtask

    // Busy is polled instead of waiting a fixed time, so divider choice does not matter
    task convert(input logic [3:0] ch, input logic [31:0] mode);
        int n;
    begin
        apb(1'b1, `OFS_CHSEL, 32'h1 << ch);
        // Quarter-rate op clock gives the synchronised comparator time for each bit
        apb(1'b1, `OFS_MODE, mode | 32'h201);
        n = 0;
        do
        begin
            apb(1'b0, `OFS_MODE, 32'h0);
            n++;
        end
        while (rdata[`MODE_RUN] !== 1'b0 && n < 1000);
        if (n >= 1000) miscompares++;
        apb(1'b0, 12'h100 + {6'h0, ch, 2'h0}, 32'h0);
    end
    endtask

    task wait_irqs(input int n);
        int k;
    begin
        for (k = 0; k < 3000 && irqs - base < n; k++)
            @(posedge clk);
        check(irqs - base, n);
    end
    endtask

    task final_report;
    begin
        $display("Comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask

    initial
    begin
        #500000;
        miscompares++;
        final_report;
    end

    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(`OFS_UPPER, {22'h0, `UPPER_RST});
        rd(`OFS_LOWER, 32'h0);
        apb(1'b0, 12'h0fc, 32'h0);
        check(err, 1'b1);
        apb(1'b1, `OFS_REFCON, 32'h1);
        // Every timing code, discharge on odd codes, test conversions interleaved
        for (i = 0; i < 16; i++)
        begin
            apb(1'b1, `OFS_TEST, (i % 2) ? i / 2 % 3 + 1 : 0);
            convert(4'h5, (i << 4) | ((i & 1) << 3));
            if (i == 0)
                norm = rdata[9:0];
            else if (i % 2 == 0)
                check(rdata[9:0], norm);
            else
                tres[i / 2 % 3 + 1] = rdata[9:0];
        end
        check(tres[1] != tres[2] && tres[2] != tres[3] && tres[1] != tres[3], 1'b1);
        check(tres[1] != norm && tres[2] != norm && tres[3] != norm, 1'b1);
        apb(1'b1, `OFS_TEST, 32'h0);
        apb(1'b1, `OFS_IRQMOD, 32'h0);
        apb(1'b1, `OFS_CHSEL, 32'h1);
        base = irqs;
        apb(1'b1, `OFS_MODE, 32'h3);
        wait_irqs(3);
        apb(1'b1, `OFS_MODE, 32'h0);
        repeat (300) @(posedge clk);
        rd(`OFS_MODE, 32'h0);
        apb(1'b1, `OFS_CHSEL, 32'h3);
        base = irqs;
        apb(1'b1, `OFS_MODE, 32'h4);
        repeat (50) @(posedge clk);
        check(irqs - base, 0);
        for (i = 0; i < 2; i++)
        begin
            apb(1'b1, `OFS_IRQMOD, i);
            base = irqs;
            halt <= (i == 1);
            trig <= 1'b1;
            repeat (4) @(posedge clk);
            trig <= 1'b0;
            wait_irqs(i + 1);
            repeat (400) @(posedge clk);
            check(irqs - base, i + 1);
            rd(`OFS_STATUS, (i << 7) | 1);
        end
        halt <= 1'b0;
        apb(1'b1, `OFS_IRQMOD, 32'h0);
        // Two threshold sets, then detection disabled, with the condition met in the second of those two runs
        for (i = 0; i < 10; i++)
        begin
            apb(1'b1, `OFS_UPPER, i < 4 ? norm + 10'h10 : norm - 10'h20);
            apb(1'b1, `OFS_LOWER, i < 4 ? norm - 10'h10 : norm - 10'h20);
            apb(1'b1, `OFS_LIMMOD, ((i % 4) << 8) | (i < 8));
            convert(4'h5, 32'h0);
            rd(`OFS_LIMSTAT, (i < 4 ? i % 2 == 0 : i < 8 && i % 4 != 0) ? 32'h20 : 32'h0);
            apb(1'b1, `OFS_LIMSTAT, 32'h20);
            rd(`OFS_LIMSTAT, 32'h0);
        end
        final_report;
    end
endmodule // tb_sar_adc_sequence_timing
